// [verilog/dcc_channel.sv]
// One DMA channel: control, status, flow control, bus master and interrupt
//
// Summary of operation
// - Control bits 15:9 pick which flow-control master drives this channel.
// - Direction 1 copies memory to device; 0 copies device to memory.
// - Busy reads 1 whenever the channel machine is not idle.
// - Done reads run and not busy; 0 when channel is off.
// - Request bit shows the selected master's live request.
// - With hardware flow control, run enables service; cleared, requests ignored.
// - Completion flag sets when memory pointer reaches memory end address.
// - Termination by the master ends transfer without the completion flag.
// - Overflow flag sets on a request after the transfer has finished.
// - Bus-error flag sets when an internal bus access returns error.
// - Three flags are interrupt sources, sticky until cleared, reset to 0.
// - Abort bit ends the current transfer at once.
// - Flow-control disable bit makes the channel ignore all master signalling.
// - Each flag has its own interrupt enable bit.
`timescale 1ns/1ns
`default_nettype none
module dcc_channel
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Flow-control interface
    input wire logic [DCC_FC_W-1:0] fc_req,
    input wire logic [DCC_FC_W-1:0] fc_term,
    output logic [DCC_FC_W-1:0] fc_ack,
    output logic [DCC_FC_W-1:0] fc_end,
    // Internal 32-bit bus master
    output logic mbus_req,
    output logic mbus_write,
    output logic [31:0] mbus_addr,
    output logic [2:0] mbus_size,
    output logic [31:0] mbus_wdata,
    input wire logic mbus_ack,
    input wire logic mbus_err,
    input wire logic [31:0] mbus_rdata,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    dcc_state_t state_q, state_d;
    logic [31:0] ctl_q;
    logic [31:0] mem_q;
    logic [31:0] end_q;
    logic [31:0] dev_q;
    logic [2:0] ien_q;
    logic term_q;
    logic wr_pend_q;
    logic [7:0] wr_ofs_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic mbus_req_q;
    logic mbus_write_q;
    logic [31:0] mbus_addr_q;
    logic [31:0] mbus_wdata_q;
    logic [DCC_FC_W-1:0] fc_ack_q;
    logic [DCC_FC_W-1:0] fc_end_q;
    logic irq_q;
    logic [2:0] stat_q;

    ////////////////////////////////////////////////////////////////////////
    // Control field decode

    wire [DCC_SEL_W-1:0] sel = ctl_q[DCC_CTL_SEL_HI:DCC_CTL_SEL_LO];
    wire dir_m2d = ctl_q[DCC_CTL_DIR];
    wire run = ctl_q[DCC_CTL_RUN];
    wire no_hwfc = ctl_q[DCC_CTL_NO_HWFC];
    wire go = ctl_q[DCC_CTL_GO];
    wire abort = ctl_q[DCC_CTL_ABORT];
    wire inc_mem = ctl_q[DCC_CTL_INC_MEM];
    wire inc_dev = ctl_q[DCC_CTL_INC_DEV];
    wire [2:0] xfer_size = ctl_q[DCC_CTL_SIZE_HI:DCC_CTL_SIZE_LO];

    // Only the master at the selected index is seen
    wire sel_req = fc_req[sel];
    wire sel_term = fc_term[sel];
    wire hw_mode = ~no_hwfc;
    // Master requests are invisible when flow control is off or run is clear
    wire hw_req = hw_mode & run & sel_req;
    wire at_end = (mem_q == end_q);

    wire busy = (state_q != DCC_IDLE);
    wire done = run & ~busy;
    wire [31:0] ctl_rd = {ctl_q[31:6], busy, 2'b00, done, sel_req, run};

    ////////////////////////////////////////////////////////////////////////
    // Bus slave decode

    wire ahb_take = hsel & hready & (htrans == DCC_HTRANS_NONSEQ);
    wire ahb_rd = ahb_take & ~hwrite;
    wire ahb_wr = ahb_take & hwrite;
    wire [7:0] ahb_ofs = {haddr[7:2], 2'b00};
    wire wr_ctl = wr_pend_q & (wr_ofs_q == DCC_OFS_CONTROL);
    wire wr_stat = wr_pend_q & (wr_ofs_q == DCC_OFS_INT_STATUS);
    wire wr_ien = wr_pend_q & (wr_ofs_q == DCC_OFS_INT_ENABLE);
    wire wr_mem = wr_pend_q & (wr_ofs_q == DCC_OFS_MEM_START);
    wire wr_end = wr_pend_q & (wr_ofs_q == DCC_OFS_MEM_END);
    wire wr_dev = wr_pend_q & (wr_ofs_q == DCC_OFS_DEV_ADDR);
    wire rd_stat = ahb_rd & (ahb_ofs == DCC_OFS_INT_STATUS);

    logic [31:0] rd_mux;
    always_comb begin
        unique case (ahb_ofs)
            DCC_OFS_MEM_START: rd_mux = mem_q;
            DCC_OFS_MEM_END: rd_mux = end_q;
            DCC_OFS_DEV_ADDR: rd_mux = dev_q;
            DCC_OFS_CONTROL: rd_mux = ctl_rd;
            DCC_OFS_INT_STATUS: rd_mux = {29'h0, stat_q};
            DCC_OFS_INT_ENABLE: rd_mux = {29'h0, ien_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel machine

    // Hardware mode starts on the selected request; firmware mode on go
    wire start = ~abort & ~at_end & (hw_mode ? hw_req : go);
    wire bus_done = mbus_req_q & mbus_ack;
    wire bus_fail = bus_done & mbus_err;
    wire pkt_done = (state_q == DCC_WRITE) & bus_done & ~mbus_err;
    wire [31:0] step = {29'h0, xfer_size};
    wire [31:0] mem_next = inc_mem ? mem_q + step : mem_q;
    wire [31:0] dev_next = inc_dev ? dev_q + step : dev_q;
    wire reach_end = pkt_done & (mem_next == end_q);
    // Termination is latched while the master asks, honoured after the packet
    wire term_seen = hw_mode & (term_q | sel_term);
    wire stop_term = pkt_done & term_seen & ~reach_end;
    // Firmware mode keeps going to the end; hardware mode waits per packet
    wire more = pkt_done & ~reach_end & ~term_seen & ~hw_mode & go;

    // Read source and write target follow the direction bit
    wire [31:0] rd_addr = dir_m2d ? mem_q : dev_q;
    wire [31:0] wr_addr = dir_m2d ? dev_q : mem_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DCC_IDLE: begin
                if (start) begin
                    state_d = DCC_READ;
                end
            end
            DCC_READ: begin
                if (bus_fail) begin
                    state_d = DCC_IDLE;
                end else if (bus_done) begin
                    state_d = DCC_WRITE;
                end
            end
            DCC_WRITE: begin
                if (bus_done) begin
                    state_d = more ? DCC_READ : DCC_IDLE;
                end
            end
        endcase
        if (abort) begin
            state_d = DCC_IDLE;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= DCC_IDLE;
            term_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == DCC_IDLE) begin
                term_q <= 1'b0;
            end else if (hw_mode && sel_term) begin
                term_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal bus master

    wire issue_rd = (state_q == DCC_IDLE && state_d == DCC_READ) ||
                    (state_q == DCC_WRITE && state_d == DCC_READ);
    wire issue_wr = (state_q == DCC_READ && state_d == DCC_WRITE);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mbus_req_q <= 1'b0;
            mbus_write_q <= 1'b0;
            mbus_addr_q <= 32'h00000000;
            mbus_wdata_q <= 32'h00000000;
        end else if (abort) begin
            mbus_req_q <= 1'b0;
        end else if (issue_rd) begin
            mbus_req_q <= 1'b1;
            mbus_write_q <= 1'b0;
            mbus_addr_q <= (state_q == DCC_WRITE) ? (dir_m2d ? mem_next : dev_next) : rd_addr;
        end else if (issue_wr) begin
            mbus_req_q <= 1'b1;
            mbus_write_q <= 1'b1;
            mbus_addr_q <= wr_addr;
            mbus_wdata_q <= mbus_rdata;
        end else if (bus_done) begin
            mbus_req_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flow-control answers

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fc_ack_q <= '0;
            fc_end_q <= '0;
        end else begin
            fc_ack_q <= '0;
            fc_end_q <= '0;
            if (pkt_done && hw_mode) begin
                fc_ack_q[sel] <= 1'b1;
                fc_end_q[sel] <= reach_end | stop_term;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
        end else begin
            wr_pend_q <= ahb_wr;
            if (ahb_take) begin
                wr_ofs_q <= ahb_ofs;
            end
            if (ahb_rd) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctl_q <= DCC_CTL_RESET;
            ien_q <= DCC_INT_RESET;
            mem_q <= 32'h00000000;
            end_q <= 32'h00000000;
            dev_q <= 32'h00000000;
        end else begin
            if (wr_ctl) begin
                ctl_q <= hwdata & DCC_CTL_WMASK;
            end else if (stop_term || reach_end) begin
                ctl_q[DCC_CTL_GO] <= 1'b0;
            end
            if (wr_ien) begin
                ien_q <= hwdata[2:0];
            end
            if (wr_end) begin
                end_q <= hwdata;
            end
            if (wr_mem) begin
                mem_q <= hwdata;
            end else if (pkt_done) begin
                mem_q <= mem_next;
            end
            if (wr_dev) begin
                dev_q <= hwdata;
            end else if (pkt_done) begin
                dev_q <= dev_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status flags

    // A request while idle at the end address is an overflow attempt
    wire ovf_evt = (state_q == DCC_IDLE) & hw_req & at_end & ~abort;
    wire [2:0] stat_clr = ({3{wr_stat}} & hwdata[2:0]) | {3{rd_stat}};

    dcc_flag u_flag_err (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_i(bus_fail),
        .clr_i(stat_clr[DCC_INT_BUS_ERR]),
        .flag_q(stat_q[DCC_INT_BUS_ERR])
    );

    dcc_flag u_flag_ovf (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_i(ovf_evt),
        .clr_i(stat_clr[DCC_INT_OVERFLOW]),
        .flag_q(stat_q[DCC_INT_OVERFLOW])
    );

    dcc_flag u_flag_done (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_i(reach_end),
        .clr_i(stat_clr[DCC_INT_DONE]),
        .flag_q(stat_q[DCC_INT_DONE])
    );

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & ien_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign fc_ack = fc_ack_q;
    assign fc_end = fc_end_q;
    assign mbus_req = mbus_req_q;
    assign mbus_write = mbus_write_q;
    assign mbus_addr = mbus_addr_q;
    assign mbus_size = xfer_size;
    assign mbus_wdata = mbus_wdata_q;
    assign irq = irq_q;

endmodule
`default_nettype wire

// [include/dcc_pkg.sv]
// Package for the DMA channel control and status block
package dcc_pkg;

    // Register byte offsets
    localparam logic [7:0] DCC_OFS_MEM_START = 8'h00;
    localparam logic [7:0] DCC_OFS_MEM_END = 8'h04;
    localparam logic [7:0] DCC_OFS_DEV_ADDR = 8'h08;
    localparam logic [7:0] DCC_OFS_CONTROL = 8'h10;
    localparam logic [7:0] DCC_OFS_INT_STATUS = 8'h14;
    localparam logic [7:0] DCC_OFS_INT_ENABLE = 8'h18;

    // Control field positions
    localparam int DCC_CTL_RUN = 0;
    localparam int DCC_CTL_REQUEST = 1;
    localparam int DCC_CTL_DONE = 2;
    localparam int DCC_CTL_BUSY = 5;
    localparam int DCC_CTL_DIR = 8;
    localparam int DCC_CTL_SEL_LO = 9;
    localparam int DCC_CTL_SEL_HI = 15;
    localparam int DCC_CTL_INC_MEM = 16;
    localparam int DCC_CTL_INC_DEV = 17;
    localparam int DCC_CTL_LOCK = 18;
    localparam int DCC_CTL_NO_HWFC = 19;
    localparam int DCC_CTL_SIZE_LO = 20;
    localparam int DCC_CTL_SIZE_HI = 22;
    localparam int DCC_CTL_GO = 24;
    localparam int DCC_CTL_ABORT = 25;

    // Writable control bits: 25:24, 22:16, 15:8, 0
    localparam logic [31:0] DCC_CTL_WMASK = 32'h037FFF01;
    localparam logic [31:0] DCC_CTL_RESET = 32'h00000000;

    // Interrupt status and enable bit positions
    localparam int DCC_INT_BUS_ERR = 0;
    localparam int DCC_INT_OVERFLOW = 1;
    localparam int DCC_INT_DONE = 2;
    localparam logic [2:0] DCC_INT_RESET = 3'h0;

    // Flow-control bus width and selector width
    localparam int DCC_SEL_W = 7;
    localparam int DCC_FC_W = 128;

    // AHB-Lite codes
    localparam logic [1:0] DCC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] DCC_HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        DCC_IDLE,
        DCC_READ,
        DCC_WRITE
    } dcc_state_t;

endpackage

// [verilog/dcc_flag.sv]
// Sticky interrupt status flag with set priority over clear
`timescale 1ns/1ns
`default_nettype none
module dcc_flag (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Event and clear
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_q
);

    logic flag_d;

    // Hardware set beats a simultaneous software clear
    assign flag_d = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_q);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule
`default_nettype wire

// [tb/dcc_partner.sv]
// Flow-control master and internal bus memory model
`timescale 1ns/1ns
`default_nettype none
module dcc_partner
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Scenario controls
    input wire logic [6:0] idx,
    input wire logic want,
    input wire logic term,
    input wire logic slow,
    input wire logic err_arm,
    input wire logic [DCC_FC_W-1:0] noise,
    // Flow control
    output logic [DCC_FC_W-1:0] fc_req,
    output logic [DCC_FC_W-1:0] fc_term,
    input wire logic [DCC_FC_W-1:0] fc_ack,
    // Internal bus
    input wire logic mbus_req,
    input wire logic mbus_write,
    input wire logic [31:0] mbus_addr,
    input wire logic [31:0] mbus_wdata,
    output logic mbus_ack,
    output logic mbus_err,
    output logic [31:0] mbus_rdata,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data
);
    logic req_q;
    logic [1:0] cnt_q;
    wire logic [DCC_FC_W-1:0] own = DCC_FC_W'(1) << idx;
    wire logic hold = req_q && ((fc_ack & own) == '0);
    wire logic [31:0] pat = mbus_addr ^ 32'hA5A50000;
    // Other masters toggle at random and must be ignored
    assign fc_req = hold ? (noise | own) : (noise & ~own);
    assign fc_term = term ? (noise | own) : (noise & ~own);
    assign mbus_err = mbus_ack && err_arm;
    assign mbus_rdata = mbus_ack ? pat : ~pat;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            req_q <= 1'b0;
            cnt_q <= 2'h0;
            mbus_ack <= 1'b0;
            wr_addr <= 32'h0;
            wr_data <= 32'h0;
        end else begin
            req_q <= want && hold || want && !req_q;
            cnt_q <= (mbus_req && !mbus_ack) ? cnt_q + 2'h1 : 2'h0;
            mbus_ack <= mbus_req && !mbus_ack && cnt_q == (slow ? 2'h3 : 2'h0);
            if (mbus_req && mbus_ack && mbus_write) begin
                wr_addr <= mbus_addr;
                wr_data <= mbus_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/dcc_channel_sva.sv]
// Port checks for the DMA channel
`timescale 1ns/1ns
`default_nettype none
module dcc_chk
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Flow control
    input wire logic [DCC_FC_W-1:0] fc_req,
    input wire logic [DCC_FC_W-1:0] fc_ack,
    input wire logic [DCC_FC_W-1:0] fc_end,
    // Internal bus and interrupt
    input wire logic mbus_req,
    input wire logic mbus_write,
    input wire logic [31:0] mbus_addr,
    input wire logic mbus_ack,
    input wire logic mbus_err,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic any_ack = fc_ack != '0;
    property p_pulse; any_ack |=> fc_ack == '0; endproperty
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    property p_onehot; $onehot0(fc_ack) && $onehot0(fc_end); endproperty
    a_onehot: assert property (p_onehot) else $error("ack on several masters");
    property p_ack_req; any_ack |-> (fc_ack & $past(fc_req)) == fc_ack; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_end_ack; fc_end != '0 |-> fc_end == fc_ack; endproperty
    a_end_ack: assert property (p_end_ack) else $error("end without ack");
    property p_ack_wr; any_ack |-> $past(mbus_req && mbus_write && mbus_ack && !mbus_err);
    endproperty
    a_ack_wr: assert property (p_ack_wr) else $error("ack before write done");
    property p_hold; mbus_req && !mbus_ack ##1 mbus_req |-> $stable(mbus_addr) && $stable(mbus_write);
    endproperty
    a_hold: assert property (p_hold) else $error("bus access changed while waiting");
    property p_err; mbus_req && mbus_ack && mbus_err |=> !mbus_req; endproperty
    a_err: assert property (p_err) else $error("access went on after error");
    property p_rd_wr; mbus_req && mbus_ack && !mbus_write && !mbus_err |=> !(mbus_req && !mbus_write);
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
    c_end: cover property (fc_end != '0);
    c_err: cover property (mbus_ack && mbus_err);
    c_irq: cover property ($rose(irq));
endmodule
bind dcc_channel dcc_chk i_chk (.ref_clk(ref_clk), .reset(reset), .fc_req(fc_req),
    .fc_ack(fc_ack), .fc_end(fc_end), .mbus_req(mbus_req), .mbus_write(mbus_write),
    .mbus_addr(mbus_addr), .mbus_ack(mbus_ack), .mbus_err(mbus_err), .irq(irq));
`default_nettype wire

// [tb/dcc_channel_tb.sv]
// Self-checking bench for the DMA channel control and status block
`timescale 1ns/1ns
`default_nettype none
module dcc_channel_tb
    import dcc_pkg::*;
;
    logic ref_clk, reset, hsel, hwrite, hreadyout, hresp, irq;
    logic mbus_req, mbus_write, mbus_ack, mbus_err, want, term, slow, err_arm;
    logic [1:0] htrans;
    logic [2:0] hsize, mbus_size;
    logic [6:0] idx;
    logic [31:0] haddr, hwdata, hrdata, mbus_addr, mbus_wdata, mbus_rdata, wr_addr, wr_data;
    logic [31:0] mem, dev, rv;
    logic [DCC_FC_W-1:0] fc_req, fc_term, fc_ack, fc_end, noise;
    int mismatches, samples_checked, acks, a0, k, n;
    dcc_channel i_dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fc_req(fc_req),
        .fc_term(fc_term), .fc_ack(fc_ack), .fc_end(fc_end), .mbus_req(mbus_req),
        .mbus_write(mbus_write), .mbus_addr(mbus_addr), .mbus_size(mbus_size),
        .mbus_wdata(mbus_wdata),
        .mbus_ack(mbus_ack), .mbus_err(mbus_err), .mbus_rdata(mbus_rdata), .irq(irq));
    dcc_partner i_far (.ref_clk(ref_clk), .reset(reset), .idx(idx), .want(want), .term(term),
        .slow(slow), .err_arm(err_arm), .noise(noise), .fc_req(fc_req), .fc_term(fc_term),
        .fc_ack(fc_ack), .mbus_req(mbus_req), .mbus_write(mbus_write), .mbus_addr(mbus_addr),
        .mbus_wdata(mbus_wdata), .mbus_ack(mbus_ack), .mbus_err(mbus_err),
        .mbus_rdata(mbus_rdata), .wr_addr(wr_addr), .wr_data(wr_data));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) noise <= {$urandom, $urandom, $urandom, $urandom};
    always @(posedge ref_clk) if (fc_ack[idx] === 1'b1) acks <= acks + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= DCC_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= DCC_HSIZE_WORD;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    function automatic logic [31:0] ctl_val(input logic dir);
        return 32'h00410001 | (32'(idx) << DCC_CTL_SEL_LO) | (32'(dir) << DCC_CTL_DIR);
    endfunction
    task automatic setup(input logic dir, input int cnt);
        mem = {16'h0, 14'($urandom), 2'h0};
        dev = {16'h1, 14'($urandom), 2'h0};
        a0 = acks;
        wr(DCC_OFS_MEM_START, mem);
        wr(DCC_OFS_MEM_END, mem + 32'(4 * cnt));
        wr(DCC_OFS_DEV_ADDR, dev);
        wr(DCC_OFS_CONTROL, ctl_val(dir));
    endtask
    task automatic wait_end;
        for (int i = 0; i < 3000 && fc_end[idx] !== 1'b1; i++) @(posedge ref_clk);
        chk(fc_end[idx], 1'b1);
    endtask
    // Run takes a few hundred cycles; limit is far beyond
    initial begin
        #2000000;
        mismatches++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {idx, want, term, slow, err_arm} = '0;
        reset = 1'b1;
        void'($urandom(26110));
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rchk(DCC_OFS_CONTROL, 32'hFFFFFFFF, 32'h0);
        chk(hresp, 1'b0);
        rchk(DCC_OFS_INT_STATUS, 32'h7, 32'h0);
        rchk(DCC_OFS_INT_ENABLE, 32'h7, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF);
        rchk(8'h1C, 32'hFFFFFFFF, 32'h0);
        for (k = 0; k < 4; k++) begin
            rv = $urandom & DCC_CTL_WMASK & ~32'h03000001;
            idx <= rv[15:9];
            want <= k[0];
            wr(DCC_OFS_CONTROL, rv);
            rchk(DCC_OFS_CONTROL, 32'hFFFFFFFF, rv | (32'(k[0]) << DCC_CTL_REQUEST));
            chk(mbus_size, rv[DCC_CTL_SIZE_HI:DCC_CTL_SIZE_LO]);
        end
        chk(acks, 0);
        wr(DCC_OFS_MEM_END, 32'h40);
        wr(DCC_OFS_CONTROL, ctl_val(1'b1) | 32'h00080000);
        repeat (20) @(posedge ref_clk);
        chk(acks, 0);
        want <= 1'b0;
        for (k = 0; k < 2; k++) begin
            n = 1 + $urandom % 4;
            slow <= k[0];
            setup(!k[0], n);
            wr(DCC_OFS_INT_ENABLE, 32'h4);
            want <= 1'b1;
            wait_end();
            want <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chk(irq, 1);
            chk(acks - a0, n);
            chk(wr_addr, k[0] ? mem + 32'(4 * (n - 1)) : dev);
            chk(wr_data, (k[0] ? dev : mem + 32'(4 * (n - 1))) ^ 32'hA5A50000);
            rchk(DCC_OFS_CONTROL, 32'h27, 32'h5);
            rchk(DCC_OFS_MEM_START, 32'hFFFFFFFF, mem + 32'(4 * n));
            rchk(DCC_OFS_INT_STATUS, 32'h7, 32'h4);
            rchk(DCC_OFS_INT_STATUS, 32'h7, 32'h0);
        end
        wr(DCC_OFS_INT_ENABLE, 32'h0);
        want <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(irq, 0);
        rchk(DCC_OFS_INT_STATUS, 32'h7, 32'h2);
        wr(DCC_OFS_INT_ENABLE, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1);
        want <= 1'b0;
        wr(DCC_OFS_INT_STATUS, 32'h7);
        rchk(DCC_OFS_INT_STATUS, 32'h7, 32'h0);
        chk(irq, 0);
        setup(1'b1, 30);
        term <= 1'b1;
        want <= 1'b1;
        wait_end();
        want <= 1'b0;
        term <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(acks - a0, 1);
        rchk(DCC_OFS_INT_STATUS, 32'h4, 32'h0);
        setup(1'b1, 4);
        err_arm <= 1'b1;
        want <= 1'b1;
        repeat (12) @(posedge ref_clk);
        want <= 1'b0;
        repeat (8) @(posedge ref_clk);
        err_arm <= 1'b0;
        rchk(DCC_OFS_INT_STATUS, 32'h1, 32'h1);
        rchk(DCC_OFS_CONTROL, 32'h20, 32'h0);
        // Firmware mode: go runs three packets back to back, no flow-control answers
        setup(1'b1, 3);
        wr(DCC_OFS_CONTROL, ctl_val(1'b1) | 32'h01080000);
        repeat (100) @(posedge ref_clk);
        chk(acks - a0, 0);
        chk(wr_addr, dev);
        chk(wr_data, (mem + 32'h8) ^ 32'hA5A50000);
        rchk(DCC_OFS_CONTROL, 32'h01000020, 32'h0);
        rchk(DCC_OFS_MEM_START, 32'hFFFFFFFF, mem + 32'hC);
        rchk(DCC_OFS_INT_STATUS, 32'h4, 32'h4);
        setup(1'b0, 30);
        want <= 1'b1;
        repeat (15) @(posedge ref_clk);
        wr(DCC_OFS_CONTROL, ctl_val(1'b0) | 32'h02000000);
        rchk(DCC_OFS_CONTROL, 32'h20, 32'h0);
        a0 = acks;
        repeat (20) @(posedge ref_clk);
        chk(acks - a0, 0);
        want <= 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
